// ### hw/cis_host.sv
`timescale 1ns/100ps
module cis_host (
  input wire logic clk, // clock
  input wire logic rstn, // async reset, low
  cis_if.host bus, // attribute read port
  input wire logic start, // begin config walk, pulse
  output logic busy, // walk in progress
  output logic done, // walk finished, pulse
  output logic [11:0] cfg_base, // found base address
  output logic [7:0] cfg_mask, // found presence mask
  output logic [7:0] cfg_last // found last index
);
  import cis_pkg::*;
  cis_state_e st_q;
  logic [CIS_ADDR_W-2:0] idx_q;
  logic [7:0] sz_q;
  logic req_q;
  logic [11:0] base_q;
  logic [7:0] mask_q, last_q;
  logic done_q;
  logic busy_q;
  logic [5:0] mask_at;
  // mask follows a base field of (size + 1) bytes that starts at byte 9
  assign mask_at = 6'd10 + {4'h0, sz_q[1:0]};
  // ---------------------------------------------------------------
  // walk: read bytes at 2k until the end marker
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CIS_IDLE;
      idx_q <= '0;
      sz_q <= 8'h00;
      req_q <= 1'b0;
      base_q <= 12'h000;
      mask_q <= 8'h00;
      last_q <= 8'h00;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      req_q <= 1'b0;
      case (st_q)
        CIS_IDLE: begin
          if (start) begin
            idx_q <= 6'(CIS_CONFIG_START);
            req_q <= 1'b1;
            busy_q <= 1'b1;
            st_q <= CIS_WAIT;
          end
        end
        CIS_WAIT: begin
          if (bus.ack) begin
            if (idx_q == 6'd7) begin
              sz_q <= bus.data;
            end else if (idx_q == 6'd8) begin
              last_q <= bus.data;
            end else if (idx_q == 6'd9) begin
              base_q[7:0] <= bus.data;
            end else if (idx_q == 6'd10 && sz_q[1:0] != 2'b00) begin
              base_q[11:8] <= bus.data[3:0];
            end else if (idx_q == mask_at) begin
              mask_q <= bus.data;
            end
            if (bus.data == CIS_END_MARK && idx_q > mask_at) begin
              st_q <= CIS_DONE;
            end else begin
              idx_q <= idx_q + 6'd1;
              req_q <= 1'b1;
            end
          end
        end
        default: begin
          done_q <= 1'b1;
          busy_q <= 1'b0;
          st_q <= CIS_IDLE;
        end
      endcase
    end
  end
  assign bus.addr = {idx_q, 1'b0};
  assign bus.req = req_q;
  assign busy = busy_q;
  assign done = done_q;
  assign cfg_base = base_q;
  assign cfg_mask = mask_q;
  assign cfg_last = last_q;
endmodule

// ### include/cis_pkg.sv
package cis_pkg;
  // ---------------------------------------------------------------
  // tuple codes and fixed values
  // ---------------------------------------------------------------
  localparam logic [7:0] CIS_MAKER_CODE = 8'h20;
  localparam logic [7:0] CIS_CONFIG_CODE = 8'h1A;
  localparam logic [7:0] CIS_CUSTOM_CODE = 8'hC0;
  localparam logic [7:0] CIS_END_MARK = 8'hFF;
  localparam logic [7:0] CIS_CFG_LINK_BASE = 8'h05;
  localparam logic [7:0] CIS_SUB_AREA_LEN = 8'h13;
  localparam logic [7:0] CIS_CUSTOM_LINK = 8'h0B;
  localparam logic [11:0] CIS_BASE_LIMIT = 12'hFFE;
  // ---------------------------------------------------------------
  // image layout (byte index, doubled on the bus)
  // ---------------------------------------------------------------
  localparam int CIS_MAKER_START = 0;
  localparam int CIS_CONFIG_START = 5;
  localparam int CIS_IMAGE_LEN = 40;
  localparam int CIS_ADDR_W = 7;
  // ---------------------------------------------------------------
  // attribute read timing
  // ---------------------------------------------------------------
  localparam int CIS_CLK_MHZ = 200;
  localparam int CIS_ACCESS_NS = 20;
  localparam int CIS_ACCESS_CYC = (CIS_ACCESS_NS * CIS_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    CIS_IDLE = 2'b00,
    CIS_WAIT = 2'b01,
    CIS_DONE = 2'b10
  } cis_state_e;
endpackage

// ### include/cis_if.sv
`timescale 1ns/100ps
interface cis_if;
  logic [cis_pkg::CIS_ADDR_W-1:0] addr;
  logic req;
  logic [7:0] data;
  logic ack;
  modport card (input addr, input req, output data, output ack);
  modport host (output addr, output req, input data, input ack);
endinterface

// ### hw/cis_card.sv
// Function
// - maker tuple: code 0x20, link, maker, info
// - config tuple opens with code 0x1A
// - config link is five plus field lengths
// - mask size field holds length minus one
// - base size field holds length minus one
// - host stops after last config index (cis_host stops at the first end marker after the mask byte instead)
// - config base address is even
// - config base address at most 0xFFE
// - presence mask bit set per implemented register
// - nineteen byte subtuple area holds custom subtuple
// - custom subtuple: number, extension, name string
`timescale 1ns/100ps
module cis_card #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] CARD_INFO = 8'h01, // arbitrary value
  parameter logic [7:0] LAST_INDEX = 8'h01,
  parameter logic [11:0] CONFIG_BASE = 12'h200,
  parameter logic [7:0] PRESENCE_MASK = 8'h01,
  parameter logic [7:0] IFACE_NUM = 8'h5B, // arbitrary value
  parameter logic [7:0] IFACE_EXT = 8'h03
) (
  input wire logic clk, // clock
  input wire logic rstn, // async reset, low
  cis_if.card bus // attribute read port
);
  import cis_pkg::*;
  // -------------------------------------------------------------
  // image
  // -------------------------------------------------------------
  localparam logic [11:0] BASE_SAFE =
    (CONFIG_BASE > CIS_BASE_LIMIT) ? CIS_BASE_LIMIT :
    {CONFIG_BASE[11:1], 1'b0};
  logic [7:0] rom [CIS_IMAGE_LEN];
  always_comb begin
    for (int i = 0; i < CIS_IMAGE_LEN; i++) begin
      rom[i] = CIS_END_MARK;
    end
    rom[0] = CIS_MAKER_CODE;
    rom[1] = 8'h04;
    rom[2] = MAKER_CODE;
    rom[3] = CARD_INFO;
    rom[4] = CIS_END_MARK;
    rom[5] = CIS_CONFIG_CODE;
    rom[6] = CIS_CFG_LINK_BASE + 8'h02 + 8'h01 + CIS_SUB_AREA_LEN;
    rom[7] = 8'h01;
    rom[8] = LAST_INDEX;
    rom[9] = BASE_SAFE[7:0];
    rom[10] = {4'h0, BASE_SAFE[11:8]};
    rom[11] = PRESENCE_MASK;
    rom[12] = CIS_CUSTOM_CODE;
    rom[13] = CIS_CUSTOM_LINK;
    rom[14] = IFACE_NUM;
    rom[15] = IFACE_EXT;
    rom[16] = 8'h43;
    rom[17] = 8'h49;
    rom[18] = 8'h46;
    rom[19] = 8'h5F;
    rom[20] = 8'h56;
    rom[21] = 8'h31;
    rom[22] = 8'h2E;
    rom[23] = 8'h30;
    rom[24] = 8'h30;
    rom[25] = 8'h00;
    rom[26] = CIS_END_MARK;
    for (int j = 27; j < 31; j++) begin
      rom[j] = 8'h00;
    end
    rom[31] = CIS_END_MARK;
  end
  // -------------------------------------------------------------
  // read port
  // -------------------------------------------------------------
  logic [CIS_ADDR_W-2:0] idx;
  logic [7:0] data_q;
  logic ack_q;
  assign idx = bus.addr[CIS_ADDR_W-1:1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus.req;
      if (bus.req) begin
        if (bus.addr[0] || idx >= CIS_IMAGE_LEN) begin
          data_q <= 8'h00;
        end else begin
          data_q <= rom[idx];
        end
      end
    end
  end
  assign bus.data = data_q;
  assign bus.ack = ack_q;
endmodule

// ### bench/cis_monitor.sv
`timescale 1ns/100ps
module cis_monitor (
  input wire logic clk, // clock
  input wire logic rstn, // async reset, low
  input wire logic [cis_pkg::CIS_ADDR_W-1:0] addr, // byte address
  input wire logic req, // read request
  input wire logic [7:0] data, // read data
  input wire logic ack // read answer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd(logic [6:0] a);
    req && addr == a;
  endsequence
  AST_ACK_NEXT: assert property (req |=> ack)
    else $error("no ack after read");
  AST_ACK_CAUSE: assert property (ack |-> $past(req))
    else $error("ack without read");
  AST_CFG_CODE: assert property (rd(7'd10) |=> data == 8'h1A)
    else $error("bad config code");
  AST_CFG_LINK: assert property (rd(7'd12) |=> data == 8'h1B)
    else $error("bad config link");
  AST_SIZE: assert property (rd(7'd14) |=> data == 8'h01)
    else $error("bad size byte");
  AST_BASE_EVEN: assert property (rd(7'd18) |=> !data[0])
    else $error("odd base");
  AST_BASE_TOP: assert property (rd(7'd20) |=> data[7:4] == 4'h0)
    else $error("base above limit");
  AST_MASK: assert property (rd(7'd22) |=> data == 8'h01)
    else $error("bad mask");
endmodule

// ### bench/test_card_info_structure_rom.sv
`timescale 1ns/100ps
module test_card_info_structure_rom;
  logic clk, rstn, start, busy, done;
  logic [11:0] cfg_base;
  logic [7:0] cfg_mask, cfg_last, rd_q;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  cis_if bus_a();
  cis_if bus_b();
  cis_card u_cis_card(.clk(clk), .rstn(rstn), .bus(bus_a));
  cis_card u_cis_card_b(.clk(clk), .rstn(rstn), .bus(bus_b));
  cis_host u_cis_host(.clk(clk), .rstn(rstn), .bus(bus_a), .start(start),
    .busy(busy), .done(done), .cfg_base(cfg_base), .cfg_mask(cfg_mask),
    .cfg_last(cfg_last));
  cis_monitor u_cis_monitor(.clk(clk), .rstn(rstn), .addr(bus_a.addr),
    .req(bus_a.req), .data(bus_a.data), .ack(bus_a.ack));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic check(logic [11:0] seen, logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(logic [6:0] a);
    bus_b.addr <= a;
    bus_b.req <= 1'b1;
    @(posedge clk);
    bus_b.req <= 1'b0;
    #1 check(bus_b.ack, 1'b1);
    rd_q = bus_b.data;
    @(posedge clk);
  endtask
  task automatic t_image;
    byte unsigned idx[17] = '{0,2,3,5,6,7,8,9,10,11,12,13,14,15,31,70,40};
    byte unsigned ev[17] = '{8'h20,8'h5A,8'h01,8'h1A,8'h1B,8'h01,8'h01,
      8'h00,8'h02,8'h01,8'hC0,8'h0B,8'h5B,8'h03,8'hFF,8'h00,8'h00};
    for (int i = 0; i < 17; i++) begin
      rd(i == 15 ? 7'h0B : 7'(idx[i] * 2));
      check(rd_q, ev[i]);
    end
  endtask
  task automatic t_walk;
    int n = 0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1 check(busy, 1'b1);
    while (n < 500 && done !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    check(n < 500, 1'b1);
    check(busy, 1'b0);
    check(cfg_base, 12'h200);
    check(cfg_mask, 8'h01);
    check(cfg_last, 8'h01);
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rstn = 0;
    start = 0;
    bus_b.addr = 0;
    bus_b.req = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_image();
    t_walk();
    rstn <= 1'b0;
    @(posedge clk);
    check(cfg_base, 12'h000);
    check(cfg_last, 8'h00);
    rstn <= 1'b1;
    t_walk();
    wrap_up();
  end
endmodule
